// file: sync_ctrl_pkg.sv
// Function
// - manual flash update command stores the user configuration into nonvolatile flash.
// - read-only 16-bit flash update counter increments once per flash update.
// - bias correction and factory restore commands also update flash and count.
// - self check command halts data, checks sensors, then resumes normal sampling.
// - self check result lands in diagnostic flag bit 5, one meaning fail.
// - data-ready pin asserts whenever new data loads into output registers.
// - control bit 0 picks data-ready polarity, one meaning active high.
// - data-ready stays quiet while any global command executes.
// - control bits 3:2 select internal, direct, scaled sync or indicator timing.
// - control bit 1 picks the active timing-pin edge, one meaning rising.
// - bit 7 linear-g, bit 6 percussion alignment; control resets to 0x00C1.
// - indicator mode samples internally and pulses the timing pin per sample.
// - scaled sync mode updates at input frequency times the scale factor.
// - scale register holds 15 bits, range 255 to 32767, reset 0x7FFF.
// - scale times input frequency within 1945..2048 Hz, else flag bit 7.
// - scaled mode time counter ticks at 24576 Hz, clears on each sync edge.
// - time counter is 16 bits, 40.69 microseconds per count.
// - direct mode timing-pin clock sets the output register update rate.
// - reading diagnostic flags clears them; persisting faults return next sample.
`default_nettype none
package sync_ctrl_pkg;
  // register byte addresses on the serial port
  localparam logic [6:0] ADDR_FLASH_UPDATE_COUNT = 7'h00;
  localparam logic [6:0] ADDR_DIAG      = 7'h02;
  localparam logic [6:0] ADDR_STAMP     = 7'h1C;
  localparam logic [6:0] ADDR_CTRL      = 7'h32;
  localparam logic [6:0] ADDR_SCALE     = 7'h34;
  localparam logic [6:0] ADDR_GCMD      = 7'h3E;
  // reset values
  localparam logic [7:0]  CTRL_RST  = 8'hC1;
  localparam logic [14:0] SCALE_RST = 15'h7FFF;
  // field positions
  localparam int CTRL_DR_POL   = 0;
  localparam int CTRL_SYNC_POL = 1;
  localparam int CTRL_MODE_LO  = 2;
  localparam int DIAG_AST      = 5;
  localparam int DIAG_SYNC     = 7;
  localparam int GCMD_BIAS     = 0;
  localparam int GCMD_RESTORE  = 1;
  localparam int GCMD_AST      = 2;
  localparam int GCMD_MFU      = 3;
  // timing
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned SAMPLE_RATE_SPS = 2048;
  localparam int unsigned SAMPLE_DIV      = CLK_HZ / SAMPLE_RATE_SPS;
  localparam int unsigned STAMP_RATE_HZ   = 24576;
  localparam int unsigned STAMP_DIV       = CLK_HZ / STAMP_RATE_HZ;
  localparam int unsigned MFU_TIME_MS     = 70;
  localparam int unsigned AST_TIME_MS     = 7;
  localparam int unsigned RESTORE_TIME_MS = 75;
  localparam int unsigned MFU_CYCLES      = MFU_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned AST_CYCLES      = AST_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned RESTORE_CYCLES  = RESTORE_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned DR_PULSE_NS     = 10000;
  localparam int unsigned DR_PULSE_CYC    = (DR_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned IND_PULSE_NS    = 5000;
  localparam int unsigned IND_PULSE_CYC   = (IND_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned LOCK_MIN_HZ     = 1945;
  localparam int unsigned LOCK_MAX_HZ     = 2048;
  // timing-pin modes
  typedef enum logic [1:0] {
    MODE_INTERNAL  = 2'b00,
    MODE_DIRECT    = 2'b01,
    MODE_SCALED    = 2'b10,
    MODE_INDICATOR = 2'b11
  } sync_mode_t;
  // global command sequencer
  typedef enum logic [1:0] {
    CMD_IDLE   = 2'b00,
    CMD_RUN    = 2'b01,
    CMD_FINISH = 2'b11
  } cmd_state_t;
endpackage
`default_nettype wire

// file: sample_sync_control.sv
`default_nettype none
module sample_sync_control #(
  parameter int unsigned SAMPLE_DIV     = sync_ctrl_pkg::SAMPLE_DIV,
  parameter int unsigned MFU_CYCLES     = sync_ctrl_pkg::MFU_CYCLES,
  parameter int unsigned AST_CYCLES     = sync_ctrl_pkg::AST_CYCLES,
  parameter int unsigned RESTORE_CYCLES = sync_ctrl_pkg::RESTORE_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic spi_sclk_in,
  input  wire logic spi_cs_n_in,
  input  wire logic spi_din_in,
  output var  logic spi_dout_out,
  input  wire logic sync_pin_in,
  output var  logic sync_pin_out,
  output var  logic sync_pin_oe_out,
  output var  logic data_ready_pin_out,
  input  wire logic sensor_check_fail_in,
  output var  logic data_load_out,
  output var  logic flash_store_out
);
  // pin synchronisers
  logic       sclk_s1_r, sclk_s2_r, sclk_s3_r;
  logic       cs_s1_r, cs_s2_r, cs_s3_r;
  logic       din_s1_r, din_s2_r;
  logic       sync_s1_r, sync_s2_r, sync_s3_r;
  // serial port
  logic [14:0] rx_r;
  logic [3:0]  bit_cnt_r;
  logic [15:0] tx_r;
  logic [15:0] rd_data_r;
  logic        dout_r;
  // registers
  logic [7:0]  ctrl_r;
  logic [14:0] scale_r;
  logic [15:0] flash_update_count_r;
  logic [7:0]  diag_r;
  logic [15:0] stamp_r;
  logic [15:0] stamp_div_r;
  // sample timing
  logic [31:0] int_div_r;
  logic [31:0] period_cnt_r;
  logic [31:0] period_r;
  logic [32:0] acc_r;
  logic        locked_r;
  logic        seen_edge_r;
  // command sequencer
  sync_ctrl_pkg::cmd_state_t cmd_state_r;
  logic [1:0]  cmd_sel_r;
  logic [31:0] cmd_cnt_r;
  logic        ast_fail_r;
  // pin drivers
  logic [15:0] dr_cnt_r;
  logic [15:0] ind_cnt_r;
  logic        dr_out_r;
  logic        sync_out_r;
  logic        sync_oe_r;
  logic        data_load_r;
  logic        flash_store_r;

  // address match gated by a frame strobe
  function automatic logic hit(input logic [6:0] a, input logic [6:0] b, input logic en);
    return en && (a == b);
  endfunction

  // serial frame decode
  wire        sclk_rise_w  = sclk_s2_r & ~sclk_s3_r;
  wire        sclk_fall_w  = ~sclk_s2_r & sclk_s3_r;
  wire        cs_fall_w    = ~cs_s2_r & cs_s3_r;
  wire        cs_act_w     = ~cs_s2_r;
  wire        frame_done_w = cs_act_w & sclk_rise_w & (bit_cnt_r == 4'hF);
  wire [15:0] frame_w      = {rx_r, din_s2_r};
  wire [6:0]  addr_w       = frame_w[14:8];
  wire [7:0]  wbyte_w      = frame_w[7:0];
  wire [6:0]  rd_addr_w    = {addr_w[6:1], 1'b0};
  wire        busy_w       = cmd_state_r != sync_ctrl_pkg::CMD_IDLE;
  wire        wr_w         = frame_done_w & frame_w[15] & ~busy_w;
  wire        rd_w         = frame_done_w & ~frame_w[15];

  // write strobes per byte
  wire wr_ctrl_w    = hit(addr_w, sync_ctrl_pkg::ADDR_CTRL, wr_w);
  wire wr_scale_lo  = hit(addr_w, sync_ctrl_pkg::ADDR_SCALE, wr_w);
  wire wr_scale_hi  = hit(addr_w, sync_ctrl_pkg::ADDR_SCALE + 7'h01, wr_w);
  wire wr_stamp_lo  = hit(addr_w, sync_ctrl_pkg::ADDR_STAMP, wr_w);
  wire wr_stamp_hi  = hit(addr_w, sync_ctrl_pkg::ADDR_STAMP + 7'h01, wr_w);
  wire wr_gcmd_w    = hit(addr_w, sync_ctrl_pkg::ADDR_GCMD, wr_w);
  wire diag_clr_w   = hit(rd_addr_w, sync_ctrl_pkg::ADDR_DIAG, rd_w);
  wire cmd_req_w    = wr_gcmd_w & (|wbyte_w[3:0]);

  // read data selection; command register and unmapped words read zero
  wire [15:0] rd_mux_w =
    (rd_addr_w == sync_ctrl_pkg::ADDR_FLASH_UPDATE_COUNT) ? flash_update_count_r :
    (rd_addr_w == sync_ctrl_pkg::ADDR_DIAG)      ? {8'h00, diag_r} :
    (rd_addr_w == sync_ctrl_pkg::ADDR_STAMP)     ? stamp_r :
    (rd_addr_w == sync_ctrl_pkg::ADDR_CTRL)      ? {8'h00, ctrl_r} :
    (rd_addr_w == sync_ctrl_pkg::ADDR_SCALE)     ? {1'b0, scale_r} : 16'h0000;

  // timing-pin mode and edges
  wire [1:0] mode_w      = ctrl_r[sync_ctrl_pkg::CTRL_MODE_LO +: 2];
  wire       pol_w       = ctrl_r[sync_ctrl_pkg::CTRL_SYNC_POL];
  wire       is_ind_w    = mode_w == sync_ctrl_pkg::MODE_INDICATOR;
  wire       is_scaled_w = mode_w == sync_ctrl_pkg::MODE_SCALED;
  wire       is_direct_w = mode_w == sync_ctrl_pkg::MODE_DIRECT;
  wire       sync_edge_w = ~is_ind_w & (pol_w ? (sync_s2_r & ~sync_s3_r) : (~sync_s2_r & sync_s3_r));
  wire       int_tick_w  = int_div_r == 32'(SAMPLE_DIV - 1);

  // scaled sync: lock test of scale times input rate against the window
  wire [31:0] meas_w      = period_cnt_r + 32'h0000_0001;
  wire [47:0] rate_num_w  = 48'(scale_r) * 48'(sync_ctrl_pkg::CLK_HZ);
  wire        in_range_w  = (rate_num_w >= 48'(meas_w) * 48'(sync_ctrl_pkg::LOCK_MIN_HZ)) &&
                            (rate_num_w <= 48'(meas_w) * 48'(sync_ctrl_pkg::LOCK_MAX_HZ));
  wire        stalled_w   = period_cnt_r > {period_r[30:0], 1'b0};
  wire [32:0] acc_sum_w   = acc_r + 33'(scale_r);
  wire        acc_tick_w  = acc_sum_w >= {1'b0, period_r};

  // sample instant per mode, and output register update
  wire sample_tick_w = is_direct_w ? sync_edge_w :
                       (is_scaled_w && locked_r) ? acc_tick_w : int_tick_w;
  wire update_w      = sample_tick_w & ~busy_w;
  wire stamp_tick_w  = stamp_div_r == 16'(sync_ctrl_pkg::STAMP_DIV - 1);

  // command selection and durations
  wire [1:0] cmd_pick_w =
    wbyte_w[sync_ctrl_pkg::GCMD_MFU]     ? 2'(sync_ctrl_pkg::GCMD_MFU) :
    wbyte_w[sync_ctrl_pkg::GCMD_RESTORE] ? 2'(sync_ctrl_pkg::GCMD_RESTORE) :
    wbyte_w[sync_ctrl_pkg::GCMD_BIAS]    ? 2'(sync_ctrl_pkg::GCMD_BIAS) : 2'(sync_ctrl_pkg::GCMD_AST);
  wire [31:0] cmd_len_w =
    (cmd_pick_w == 2'(sync_ctrl_pkg::GCMD_MFU))     ? 32'(MFU_CYCLES) :
    (cmd_pick_w == 2'(sync_ctrl_pkg::GCMD_RESTORE)) ? 32'(RESTORE_CYCLES) :
    (cmd_pick_w == 2'(sync_ctrl_pkg::GCMD_AST))     ? 32'(AST_CYCLES) : 32'h0000_0000;
  wire is_bias_w    = cmd_sel_r == 2'(sync_ctrl_pkg::GCMD_BIAS);
  wire cmd_done_w   = is_bias_w ? sample_tick_w : (cmd_cnt_r == 32'h0000_0000);
  wire finish_w     = cmd_state_r == sync_ctrl_pkg::CMD_FINISH;
  wire fin_flash_w  = finish_w & (cmd_sel_r != 2'(sync_ctrl_pkg::GCMD_AST));
  wire fin_ast_w    = finish_w & (cmd_sel_r == 2'(sync_ctrl_pkg::GCMD_AST));
  wire fin_rest_w   = finish_w & (cmd_sel_r == 2'(sync_ctrl_pkg::GCMD_RESTORE));

  // diagnostic flags: sets win over the clear-on-read; a finished self check replaces bit 5
  wire       ast_bit_w   = (fin_ast_w & sensor_check_fail_in) | (sample_tick_w & ast_fail_r & ~fin_ast_w);
  wire [7:0] diag_set_w  = {sample_tick_w & is_scaled_w & ~locked_r, 1'b0, ast_bit_w, 5'b00000};
  wire [7:0] diag_keep_w = (diag_clr_w ? 8'h00 : diag_r) & ~{2'b00, fin_ast_w, 5'b00000};
  wire [7:0] diag_nxt    = diag_keep_w | diag_set_w;

  // synchronisers: first stage read only by the second
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= 3'b111;
      {cs_s1_r, cs_s2_r, cs_s3_r}       <= 3'b111;
      {din_s1_r, din_s2_r}              <= 2'b00;
      {sync_s1_r, sync_s2_r, sync_s3_r} <= 3'b000;
    end else begin
      {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= {spi_sclk_in, sclk_s1_r, sclk_s2_r};
      {cs_s1_r, cs_s2_r, cs_s3_r}       <= {spi_cs_n_in, cs_s1_r, cs_s2_r};
      {din_s1_r, din_s2_r}              <= {spi_din_in, din_s1_r};
      {sync_s1_r, sync_s2_r, sync_s3_r} <= {sync_pin_in, sync_s1_r, sync_s2_r};
    end
  end

  // serial shifter: in on sclk rise, out on sclk fall, reply loaded at select
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_r      <= 15'h0000;
      bit_cnt_r <= 4'h0;
      tx_r      <= 16'h0000;
      dout_r    <= 1'b0;
    end else begin
      dout_r <= tx_r[15];
      if (!cs_act_w) begin
        bit_cnt_r <= 4'h0;
      end else if (sclk_rise_w) begin
        rx_r      <= frame_w[14:0];
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (cs_fall_w) begin
        tx_r <= rd_data_r;
      end else if (cs_act_w && sclk_fall_w && bit_cnt_r != 4'h0) begin
        tx_r <= {tx_r[14:0], 1'b0};
      end
    end
  end

  // read reply for the next frame, clear-on-read flags
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_r <= 16'h0000;
      diag_r    <= 8'h00;
    end else begin
      if (rd_w) begin
        rd_data_r <= rd_mux_w;
      end
      diag_r <= diag_nxt;
    end
  end

  // user configuration registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_r  <= sync_ctrl_pkg::CTRL_RST;
      scale_r <= sync_ctrl_pkg::SCALE_RST;
    end else if (fin_rest_w) begin
      ctrl_r  <= sync_ctrl_pkg::CTRL_RST;
      scale_r <= sync_ctrl_pkg::SCALE_RST;
    end else begin
      if (wr_ctrl_w) ctrl_r <= wbyte_w;
      if (wr_scale_lo) scale_r[7:0] <= wbyte_w;
      if (wr_scale_hi) scale_r[14:8] <= wbyte_w[6:0];
    end
  end

  // internal 2048 SPS divider and 24576 Hz time counter
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      int_div_r   <= 32'h0000_0000;
      stamp_div_r <= 16'h0000;
      stamp_r     <= 16'h0000;
    end else begin
      int_div_r <= int_tick_w ? 32'h0000_0000 : int_div_r + 32'h0000_0001;
      if (is_scaled_w && sync_edge_w) begin
        stamp_div_r <= 16'h0000;
        stamp_r     <= 16'h0000;
      end else begin
        stamp_div_r <= stamp_tick_w ? 16'h0000 : stamp_div_r + 16'h0001;
        if (wr_stamp_lo) stamp_r[7:0] <= wbyte_w;
        else if (wr_stamp_hi) stamp_r[15:8] <= wbyte_w;
        else if (is_scaled_w && stamp_tick_w) stamp_r <= stamp_r + 16'h0001;
      end
    end
  end

  // scaled sync tracking: period measure, lock, rate accumulator
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      period_cnt_r <= 32'h0000_0000;
      period_r     <= 32'h0000_0000;
      acc_r        <= 33'h0_0000_0000;
      locked_r     <= 1'b0;
      seen_edge_r  <= 1'b0;
    end else if (!is_scaled_w) begin
      locked_r    <= 1'b0;
      seen_edge_r <= 1'b0;
    end else if (sync_edge_w) begin
      period_cnt_r <= 32'h0000_0000;
      period_r     <= meas_w;
      acc_r        <= 33'h0_0000_0000;
      seen_edge_r  <= 1'b1;
      locked_r     <= seen_edge_r & in_range_w;
    end else begin
      period_cnt_r <= meas_w;
      acc_r        <= acc_tick_w ? acc_sum_w - {1'b0, period_r} : acc_sum_w;
      if (stalled_w) locked_r <= 1'b0;
    end
  end

  // global command sequencer, one-shot triggers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmd_state_r <= sync_ctrl_pkg::CMD_IDLE;
      cmd_sel_r   <= 2'b00;
      cmd_cnt_r   <= 32'h0000_0000;
    end else begin
      case (cmd_state_r)
        sync_ctrl_pkg::CMD_IDLE: begin
          if (cmd_req_w) begin
            cmd_state_r <= sync_ctrl_pkg::CMD_RUN;
            cmd_sel_r   <= cmd_pick_w;
            cmd_cnt_r   <= cmd_len_w;
          end
        end
        sync_ctrl_pkg::CMD_RUN: begin
          if (cmd_done_w) cmd_state_r <= sync_ctrl_pkg::CMD_FINISH;
          else cmd_cnt_r <= cmd_cnt_r - 32'h0000_0001;
        end
        default: cmd_state_r <= sync_ctrl_pkg::CMD_IDLE;
      endcase
    end
  end

  // command results: flash count, flash store strobe, self check verdict
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flash_update_count_r   <= 16'h0000;
      flash_store_r <= 1'b0;
      ast_fail_r    <= 1'b0;
    end else begin
      flash_store_r <= fin_flash_w;
      if (fin_flash_w) flash_update_count_r <= flash_update_count_r + 16'h0001;
      if (fin_ast_w) ast_fail_r <= sensor_check_fail_in;
    end
  end

  // data-ready pulse and indicator pulse
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dr_cnt_r    <= 16'h0000;
      ind_cnt_r   <= 16'h0000;
      data_load_r <= 1'b0;
    end else begin
      data_load_r <= update_w;
      if (busy_w) dr_cnt_r <= 16'h0000;
      else if (update_w) dr_cnt_r <= 16'(sync_ctrl_pkg::DR_PULSE_CYC);
      else if (dr_cnt_r != 16'h0000) dr_cnt_r <= dr_cnt_r - 16'h0001;
      if (is_ind_w && int_tick_w) ind_cnt_r <= 16'(sync_ctrl_pkg::IND_PULSE_CYC);
      else if (ind_cnt_r != 16'h0000) ind_cnt_r <= ind_cnt_r - 16'h0001;
    end
  end

  // pin levels with polarity applied
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dr_out_r   <= 1'b0;
      sync_out_r <= 1'b0;
      sync_oe_r  <= 1'b0;
    end else begin
      dr_out_r   <= ctrl_r[sync_ctrl_pkg::CTRL_DR_POL] ~^ (dr_cnt_r != 16'h0000);
      sync_out_r <= pol_w ~^ (ind_cnt_r != 16'h0000);
      sync_oe_r  <= is_ind_w;
    end
  end

  assign spi_dout_out       = dout_r;
  assign data_ready_pin_out = dr_out_r;
  assign sync_pin_out       = sync_out_r;
  assign sync_pin_oe_out    = sync_oe_r;
  assign data_load_out      = data_load_r;
  assign flash_store_out    = flash_store_r;

  // checks
  a_flash_count_step: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    flash_store_out |-> flash_update_count_r == $past(flash_update_count_r) + 16'h0001) else $error("flash count did not step");
  a_flash_on_restore: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    fin_rest_w |=> flash_store_out && ctrl_r == sync_ctrl_pkg::CTRL_RST) else $error("restore missed");
  a_dr_quiet_busy: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cmd_state_r == sync_ctrl_pkg::CMD_RUN)[*4] |-> $stable(data_ready_pin_out)) else $error("dr moved");
  a_dr_polarity: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    data_load_out |=> data_ready_pin_out == ctrl_r[sync_ctrl_pkg::CTRL_DR_POL]) else $error("dr level wrong");
  a_no_load_busy: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    busy_w |=> !data_load_out) else $error("data loaded while busy");
  a_ast_result_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    fin_ast_w && sensor_check_fail_in |=> diag_r[sync_ctrl_pkg::DIAG_AST] && ast_fail_r) else $error("ast flag");
  a_stamp_clear_edge: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    is_scaled_w && sync_edge_w |=> stamp_r == 16'h0000) else $error("stamp not cleared");
  a_indicator_drive: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    is_ind_w && int_tick_w |=> ##1 sync_pin_oe_out && sync_pin_out == pol_w) else $error("indicator pulse");
  a_direct_update: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    is_direct_w && sync_edge_w && !busy_w |=> data_load_out) else $error("direct edge lost");
  a_sync_fail_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    is_scaled_w && !locked_r && sample_tick_w |=> diag_r[sync_ctrl_pkg::DIAG_SYNC]) else $error("sync flag");
endmodule
`default_nettype wire

// file: host_spi_model.sv
`default_nettype none
// host side of the serial port; the link clock stands high between frames
module host_spi_model (
  output var  logic spi_sclk_out,
  output var  logic spi_cs_n_out,
  output var  logic spi_din_out,
  input  wire logic spi_dout_in
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF_NS = 100;  // 200 ns link clock period
  // idle: clock high, device deselected
  initial begin
    spi_sclk_out = 1'b1;
    spi_cs_n_out = 1'b1;
    spi_din_out  = 1'b0;
  end
  // one 16-bit frame msb first; reply bits taken late in the high phase, clear of the output lag
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    spi_cs_n_out = 1'b0;
    #(HALF_NS);
    for (int i = 15; i >= 0; i--) begin
      spi_sclk_out = 1'b0;
      spi_din_out  = tx[i];
      #(HALF_NS);
      spi_sclk_out = 1'b1;
      #(HALF_NS);
      rx[i] = spi_dout_in;
    end
    spi_cs_n_out = 1'b1;
    spi_din_out  = ~spi_din_out;  // released line shows no stale bit
    #(4 * HALF_NS);
  endtask
endmodule
`default_nettype wire

// file: sample_sync_and_data_ready_control_tb.sv
`default_nettype none
module sample_sync_and_data_ready_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SDIV = 1000;
  localparam int CCYC = 3000;
  localparam logic [7:0] CMDS [3] = '{8'h08, 8'h01, 8'h02};
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        sync_in = 1'b0;
  logic        fail_in = 1'b0;
  wire         sclk, cs_n, din, dout, sync_out, sync_oe, dr, load, store;
  int          failures = 0;
  int          total_checks = 0;
  int          loads = 0;
  int          stores = 0;
  int          cycles = 0;
  int          n0, s0, f;
  logic [15:0] v, w;

  sample_sync_control #(.SAMPLE_DIV(SDIV), .MFU_CYCLES(CCYC), .AST_CYCLES(CCYC), .RESTORE_CYCLES(CCYC)) dut_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_din_in(din),
    .spi_dout_out(dout), .sync_pin_in(sync_in), .sync_pin_out(sync_out), .sync_pin_oe_out(sync_oe),
    .data_ready_pin_out(dr), .sensor_check_fail_in(fail_in), .data_load_out(load), .flash_store_out(store));
  host_spi_model host_u (.spi_sclk_out(sclk), .spi_cs_n_out(cs_n), .spi_din_out(din), .spi_dout_in(dout));

  always #12.5 clk_in = ~clk_in;
  // pulse tallies taken mid-cycle, and the hang guard
  always @(negedge clk_in) begin
    cycles <= cycles + 1;
    if (load === 1'b1) loads <= loads + 1;
    if (store === 1'b1) stores <= stores + 1;
    if (cycles == 90000) begin
      failures++;
      summarize();
    end
  end

  // comparison, bus frames and waits shared by all scenarios
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    host_u.xfer({1'b1, a, d}, r);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    logic [15:0] r;
    host_u.xfer({1'b0, a, 8'h00}, r);
    host_u.xfer(16'h0000, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic wait_load();
    int k;
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (load !== 1'b1 && k < 3 * SDIV);
  endtask
  // control byte with the unused pair kept at zero
  function automatic logic [7:0] ctrl(input logic [1:0] m, input logic e, input logic p);
    return {2'b11, 2'b00, m, e, p};
  endfunction
  function automatic logic [15:0] stamp_exp(input int c);
    return 16'(c / sync_ctrl_pkg::STAMP_DIV);
  endfunction
  task automatic summarize();
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    f = $urandom(64);
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    cyc(10);
    rd(sync_ctrl_pkg::ADDR_CTRL, v);
    check(v, 16'h00C1);
    rd(sync_ctrl_pkg::ADDR_SCALE, v);
    check(v, 16'h7FFF);
    rd(sync_ctrl_pkg::ADDR_FLASH_UPDATE_COUNT, v);
    check(v, 16'h0000);
    rd(sync_ctrl_pkg::ADDR_GCMD, v);
    check(v, 16'h0000);
    for (int p = 1; p >= 0; p--) begin
      wr(sync_ctrl_pkg::ADDR_CTRL, ctrl(2'b00, 1'b0, p[0]));
      wait_load();
      n0 = cycles;
      cyc(1);
      check(16'(dr), 16'(p[0]));
      cyc(399);
      check(16'(dr), 16'(p[0]));
      cyc(1);
      check(16'(dr), 16'(!p[0]));
      wait_load();
      check(16'(cycles - n0), 16'(SDIV));
    end
    for (int i = 0; i < 3; i++) begin
      wr(sync_ctrl_pkg::ADDR_CTRL, ctrl(2'b00, 1'b1, 1'b0));
      wr(sync_ctrl_pkg::ADDR_GCMD, CMDS[i]);
      n0 = loads;
      s0 = stores;
      if (i != 1) begin
        cyc(CCYC - 30);  // margin for the frame tail that runs after the command starts
        check(16'(loads - n0), 16'h0000);
      end
      for (int k = 0; k < 3 * SDIV && stores == s0; k++) cyc(1);
      cyc(20);
      check(16'(stores - s0), 16'h0001);
      rd(sync_ctrl_pkg::ADDR_FLASH_UPDATE_COUNT, v);
      check(v, 16'(i + 1));
    end
    rd(sync_ctrl_pkg::ADDR_CTRL, v);
    check(v, 16'h00C1);
    f = $urandom_range(1, 0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_in);
      fail_in <= f[0] ^ i[0];
      wr(sync_ctrl_pkg::ADDR_GCMD, 8'h04);
      n0 = loads;
      cyc(CCYC - 30);
      check(16'(loads - n0), 16'h0000);
      cyc(2 * SDIV);
      check(16'(loads > n0), 16'h0001);
      rd(sync_ctrl_pkg::ADDR_DIAG, v);
      check(16'(v[5]), 16'(f[0] ^ i[0]));
      wait_load();
      cyc(2);
      rd(sync_ctrl_pkg::ADDR_DIAG, v);
      check(16'(v[5]), 16'(f[0] ^ i[0]));
    end
    v = 16'(32768 / $urandom_range(128, 1) - 1);
    wr(sync_ctrl_pkg::ADDR_SCALE, v[7:0]);
    wr(sync_ctrl_pkg::ADDR_SCALE + 7'd1, v[15:8]);
    rd(sync_ctrl_pkg::ADDR_SCALE, w);
    check(w, v);
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_in);
      sync_in <= !p[0];
      wr(sync_ctrl_pkg::ADDR_CTRL, ctrl(2'b01, p[0], 1'b1));
      for (int k = 0; k < 2; k++) begin
        n0 = loads;
        @(posedge clk_in);
        sync_in <= p[0];
        cyc(10);
        check(16'(loads - n0), 16'h0001);
        @(posedge clk_in);
        sync_in <= !p[0];
        cyc(SDIV + 100);
        check(16'(loads - n0), 16'h0001);
      end
      check(16'(sync_oe), 16'h0000);
    end
    for (int p = 0; p < 2; p++) begin
      wr(sync_ctrl_pkg::ADDR_CTRL, ctrl(2'b11, p[0], 1'b1));
      wait_load();
      n0 = cycles;
      check(16'({sync_oe, sync_out}), 16'({1'b1, !p[0]}));
      cyc(1);
      check(16'({sync_oe, sync_out}), 16'({1'b1, p[0]}));
      wait_load();
      check(16'(cycles - n0), 16'(SDIV));
    end
    @(posedge clk_in);
    sync_in <= 1'b0;
    wr(sync_ctrl_pkg::ADDR_CTRL, ctrl(2'b10, 1'b1, 1'b1));
    for (int t = 16950; t >= 0; t -= 16950) begin
      @(posedge clk_in);
      sync_in <= 1'b1;
      cyc(t);
      rd(sync_ctrl_pkg::ADDR_STAMP, v);
      check(v, stamp_exp(t + 135));
      @(posedge clk_in);
      sync_in <= 1'b0;
    end
    summarize();
  end
endmodule
`default_nettype wire
